// ===== io_link_port_diag_status.sv
`timescale 1ns/1ps
`default_nettype none
module io_link_port_diag_status
    import diag_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire port_cond_t            i_cond [NUM_PORTS],
    output logic [NUM_PORTS*8-1:0]     o_cyclic_status,
    input  wire logic                  i_dict_rd,
    input  wire logic [15:0]           i_dict_index,
    input  wire logic [7:0]            i_dict_subindex,
    output logic                       o_dict_ack,
    output logic                       o_dict_ok,
    output logic [7:0]                 o_dict_data,
    input  wire logic                  i_acc_fail,
    input  wire access_err_t           i_acc_err,
    output logic                       o_acc_valid,
    output logic [31:0]                o_host_access_return_code,
    input  wire logic                  i_map_wr,
    input  wire logic [15:0]           i_map_index,
    input  wire logic [7:0]            i_map_subindex,
    output logic                       o_map_reject,
    output safe_map_t                  o_safe_map
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] port_status [NUM_PORTS];
    genvar g;
    generate
        for (g = 0; g < NUM_PORTS; g++) begin : g_port
            port_status_enc u_enc (
                .i_clk    (i_clk),
                .i_rst_n  (i_rst_n),
                .i_cond   (i_cond[g]),
                .o_status (port_status[g])
            );
            assign o_cyclic_status[g*8 +: 8] = port_status[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic        dict_ack;
        logic        dict_ok;
        logic [7:0]  dict_data;
        logic        acc_valid;
        logic [31:0] ret_code;
        logic        map_reject;
        safe_map_t   map;
    } top_state_t;
    top_state_t s_q;
    top_state_t s_d;
    logic [7:0] add_code;
    logic [3:0] a_digit;
    logic [3:0] b_digit;

    always_comb begin
        s_d = s_q;
        s_d.dict_ack   = 1'b0;
        s_d.acc_valid  = 1'b0;
        s_d.map_reject = 1'b0;
        a_digit = i_map_index[7:4];
        b_digit = i_map_index[3:0];
        // subindex n+1 selects port n; subindex 0 and out of range answer not ok
        if (i_dict_rd) begin
            s_d.dict_ack = 1'b1;
            s_d.dict_ok  = 1'b0;
            s_d.dict_data = 8'h00;
            if (i_dict_index == DICT_STATUS_INDEX && i_dict_subindex != 8'h00
                && i_dict_subindex <= 8'(NUM_PORTS)) begin
                s_d.dict_ok   = 1'b1;
                s_d.dict_data = port_status[2'(i_dict_subindex - 8'h01)];
            end
        end
        case (i_acc_err)
            ACC_REFUSED:     add_code = application_refusal_error;
            ACC_NO_INDEX:    add_code = missing_index_error;
            ACC_NO_SUBINDEX: add_code = missing_subindex_error;
            ACC_BLK_STATE:   add_code = service_blocked_by_state;
            ACC_BLK_LOCAL:   add_code = service_blocked_local_operation;
            ACC_BLK_REMOTE:  add_code = service_blocked_remote_operation;
            default:         add_code = application_refusal_error;
        endcase
        if (i_acc_fail) begin
            s_d.acc_valid = 1'b1;
            s_d.ret_code  = {ERR_APP_DEVICE, add_code, GENERAL_ERROR_LOW};
        end
        // malformed index leaves the previous mapping in force
        if (i_map_wr) begin
            if (i_map_index[15:8] == SAFE_INDEX_HIGH && a_digit <= SAFE_PORT_MAX
                && b_digit <= SAFE_TYPE_MAX && i_map_subindex != 8'h00) begin
                s_d.map.valid       = 1'b1;
                s_d.map.port        = a_digit[1:0];
                s_d.map.dtype       = safe_type_t'(b_digit[2:0]);
                s_d.map.byte_offset = i_map_subindex - 8'h01;
            end else begin
                s_d.map_reject = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.map <= '{valid: 1'b1, port: SAFE_DEF_PORT, dtype: DT_UINT,
                         byte_offset: SAFE_DEF_OFFSET};
        end else begin
            s_q <= s_d;
        end
    end

    assign o_dict_ack  = s_q.dict_ack;
    assign o_dict_ok   = s_q.dict_ok;
    assign o_dict_data = s_q.dict_data;
    assign o_acc_valid = s_q.acc_valid;
    assign o_host_access_return_code = s_q.ret_code;
    assign o_map_reject = s_q.map_reject;
    assign o_safe_map   = s_q.map;

    ////////////////////////////////////////////////////////////////////////////
    sequence acc_req_s;
        i_acc_fail;
    endsequence
    sequence acc_err_s(access_err_t e);
        i_acc_fail && i_acc_err == e;
    endsequence
    ret_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_req_s |=> o_acc_valid && o_host_access_return_code[15:0] == 16'h0700
        && o_host_access_return_code[31:24] == 8'h80)
        else $error("return code frame wrong");
    no_index_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_NO_INDEX)
        |=> o_host_access_return_code == 32'h80110700)
        else $error("missing index code wrong");
    no_sub_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_NO_SUBINDEX)
        |=> o_host_access_return_code[23:16] == 8'h12)
        else $error("missing subindex code wrong");
    refused_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_REFUSED)
        |=> o_host_access_return_code[23:16] == 8'h00)
        else $error("refusal code wrong");
    blk_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_BLK_STATE)
        |=> o_host_access_return_code[23:16] == 8'h20)
        else $error("state block code wrong");
    blk_local_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_BLK_LOCAL)
        |=> o_host_access_return_code[23:16] == 8'h21)
        else $error("local block code wrong");
    blk_remote_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        acc_err_s(ACC_BLK_REMOTE)
        |=> o_host_access_return_code[23:16] == 8'h22)
        else $error("remote block code wrong");
    map_decode_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_map_wr && i_map_index == 16'h6011 && i_map_subindex == 8'h01)
        |=> o_safe_map.port == 2'h1 && o_safe_map.dtype == DT_UDINT
        && o_safe_map.byte_offset == 8'h00)
        else $error("mapping decode wrong");
    dict_match_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_dict_rd && i_dict_index == 16'hF100 && i_dict_subindex == 8'h01)
        |=> o_dict_ok && o_dict_data == $past(port_status[0]))
        else $error("dictionary status mismatch");
    map_default_a: assert property (@(posedge i_clk)
        $rose(i_rst_n) |-> o_safe_map.dtype == DT_UINT && o_safe_map.port == 2'h0)
        else $error("default mapping wrong");
    dict_ack_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_dict_rd |=> o_dict_ack)
        else $error("dictionary ack missing");
    dict_refuse_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_dict_rd && i_dict_index != 16'hF100) |=> !o_dict_ok && o_dict_data == 8'h00)
        else $error("foreign index answered");
    acc_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_acc_fail |=> !o_acc_valid && $stable(o_host_access_return_code))
        else $error("return code moved without a failure");
    map_reject_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_map_wr && i_map_index[15:8] != 8'h60) |=> o_map_reject && $stable(o_safe_map))
        else $error("foreign mapping index accepted");
endmodule
`default_nettype wire

// ===== diag_pkg.sv
// Function
// - each port owns its own eight-bit status byte, in cyclic data and dictionary.
// - upper nibble carries the error cause code, 0x1 through 0xB.
// - lower nibble carries the port state code, 0 through 4.
// - lower nibble value 8 flags invalid process data, alongside a state.
// - simultaneous conditions are reported as the sum of their codes; cause sums cap at 0xB.
// - failed host access returns error, additional code, then 0x0700.
// - application refusal without detail gives 0x80 with additional 0x00.
// - missing index gives 0x80 with additional code 0x11.
// - missing subindex gives 0x80 with additional code 0x12.
// - blocked by application state gives 0x80 with additional 0x20.
// - blocked by local operation gives 0x80 with additional 0x21.
// - blocked by remote teach-in or calibration gives 0x80 with 0x22.
// - safety mapping index 0x60ab:0c decodes port, type and byte offset.
// - default safety mapping is UINT from port 0 byte offset 0.
package diag_pkg;
    localparam int NUM_PORTS = 4;
    localparam logic [15:0] DICT_STATUS_INDEX = 16'hF100;
    // port states
    typedef enum logic [2:0] {
        ST_DISABLED, ST_DIG_IN, ST_DIG_OUT, ST_OPERATE, ST_COMM_HALTED
    } port_state_t;
    localparam logic [3:0] LO_DISABLED  = 4'h0;
    localparam logic [3:0] LO_DIG_IN    = 4'h1;
    localparam logic [3:0] LO_DIG_OUT   = 4'h2;
    localparam logic [3:0] LO_OPERATE   = 4'h3;
    localparam logic [3:0] LO_HALTED    = 4'h4;
    localparam logic [3:0] LO_PD_INVAL  = 4'h8;
    localparam logic [3:0] HI_NONE      = 4'h0;
    localparam logic [3:0] HI_MAX       = 4'hB;
    // cause flags, one bit per cause code 1..11
    localparam int NUM_CAUSES = 11;
    typedef struct packed {
        logic [NUM_CAUSES-1:0] cause;
        logic                  pd_invalid;
        port_state_t           state;
    } port_cond_t;
    // host access errors
    typedef enum logic [2:0] {
        ACC_REFUSED, ACC_NO_INDEX, ACC_NO_SUBINDEX,
        ACC_BLK_STATE, ACC_BLK_LOCAL, ACC_BLK_REMOTE
    } access_err_t;
    localparam logic [7:0]  ERR_APP_DEVICE           = 8'h80;
    localparam logic [7:0]  application_refusal_error = 8'h00;
    localparam logic [7:0]  missing_index_error      = 8'h11;
    localparam logic [7:0]  missing_subindex_error   = 8'h12;
    localparam logic [7:0]  service_blocked_by_state = 8'h20;
    localparam logic [7:0]  service_blocked_local_operation  = 8'h21;
    localparam logic [7:0]  service_blocked_remote_operation = 8'h22;
    localparam logic [15:0] GENERAL_ERROR_LOW        = 16'h0700;
    // safety mapping index
    localparam logic [7:0] SAFE_INDEX_HIGH = 8'h60;
    localparam logic [3:0] SAFE_PORT_MAX   = 4'h3;
    typedef enum logic [2:0] {
        DT_BIT, DT_UDINT, DT_DINT, DT_UINT, DT_INT
    } safe_type_t;
    localparam logic [3:0] SAFE_TYPE_MAX = 4'h4;
    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        safe_type_t dtype;
        logic [7:0] byte_offset;
    } safe_map_t;
    localparam logic [7:0] SAFE_DEF_OFFSET = 8'h00;
    localparam logic [1:0] SAFE_DEF_PORT   = 2'h0;
endpackage

// ===== port_status_enc.sv
`timescale 1ns/1ps
`default_nettype none
module port_status_enc
    import diag_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire port_cond_t i_cond,
    output logic [7:0]      o_status
);
    typedef struct packed {
        logic [7:0] status;
    } enc_state_t;
    enc_state_t s_q;
    enc_state_t s_d;
    logic [3:0] lo;
    logic [7:0] hi_sum;

    always_comb begin
        s_d = s_q;
        hi_sum = 8'h00;
        // sum of active cause codes; software sees the plain code when one is set
        for (int k = 0; k < NUM_CAUSES; k++) begin
            if (i_cond.cause[k]) begin
                hi_sum = hi_sum + 8'(k + 1);
            end
        end
        case (i_cond.state)
            ST_DISABLED:    lo = LO_DISABLED;
            ST_DIG_IN:      lo = LO_DIG_IN;
            ST_DIG_OUT:     lo = LO_DIG_OUT;
            ST_OPERATE:     lo = LO_OPERATE;
            ST_COMM_HALTED: lo = LO_HALTED;
            default:        lo = LO_DISABLED;
        endcase
        if (i_cond.pd_invalid) begin
            lo = lo + LO_PD_INVAL;
        end
        // nibble wraps on heavy cause sums; clipped to the largest code instead
        s_d.status = {(hi_sum > 8'(HI_MAX)) ? HI_MAX : hi_sum[3:0], lo};
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_status = s_q.status;

    no_bad_state_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !(o_status[3:0] inside {4'h5, 4'h6, 4'h7}))
        else $error("undefined lower nibble code");
    op_invalid_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cond.state == ST_OPERATE && i_cond.pd_invalid && i_cond.cause == '0)
        |=> o_status == 8'h0B)
        else $error("operate plus invalid not 0x0B");
    one_cause_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_cond.cause == 11'h200) |=> o_status[7:4] == 4'hA)
        else $error("no device cause not 0xA");
    inval_flag_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_cond.pd_invalid |=> o_status[3])
        else $error("invalid flag missing");
endmodule
`default_nettype wire

// ===== io_device_model.sv
`timescale 1ns/1ps
`default_nettype none
module io_device_model
    import diag_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_load,
    input  wire logic [1:0] i_port,
    input  wire port_cond_t i_cond,
    output var port_cond_t  o_cond [NUM_PORTS]
);
    // zero from time 0 so the port logic never sees an unknown condition
    port_cond_t held [NUM_PORTS] = '{default: '0};
    ////////////////////////////////////////////////////////////////
    // a device reports a new condition only at a clock edge
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            held <= '{default: '0};
        end else if (i_load) begin
            held[i_port] <= i_cond;
        end
    end
    always_comb begin
        o_cond = held;
    end
endmodule
`default_nettype wire

// ===== io_link_port_diag_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module io_link_port_diag_status_bench
    import diag_pkg::*;
;
    logic i_clk, i_rst_n, i_load, i_dict_rd, i_acc_fail, i_map_wr;
    logic o_dict_ack, o_dict_ok, o_acc_valid, o_map_reject;
    logic [1:0] ld_port;
    logic [7:0] i_dict_subindex, i_map_subindex, o_dict_data;
    logic [15:0] i_dict_index, i_map_index;
    logic [31:0] o_cyclic_status, o_host_access_return_code;
    port_cond_t ld_cond, i_cond [NUM_PORTS], exp_c [NUM_PORTS];
    access_err_t i_acc_err;
    safe_map_t o_safe_map;
    int num_errors = 0;
    int compares = 0;
    io_device_model model (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_load(i_load),
        .i_port(ld_port), .i_cond(ld_cond), .o_cond(i_cond));
    io_link_port_diag_status dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cond(i_cond),
        .o_cyclic_status(o_cyclic_status), .i_dict_rd(i_dict_rd),
        .i_dict_index(i_dict_index), .i_dict_subindex(i_dict_subindex),
        .o_dict_ack(o_dict_ack), .o_dict_ok(o_dict_ok), .o_dict_data(o_dict_data),
        .i_acc_fail(i_acc_fail), .i_acc_err(i_acc_err), .o_acc_valid(o_acc_valid),
        .o_host_access_return_code(o_host_access_return_code), .i_map_wr(i_map_wr),
        .i_map_index(i_map_index), .i_map_subindex(i_map_subindex),
        .o_map_reject(o_map_reject), .o_safe_map(o_safe_map));
    ////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    task tick;
        @(posedge i_clk);
        #2;
    endtask
    task check8(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task check32(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task end_sim;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // sums above 0x0B clip to the top cause code
    function automatic logic [7:0] exp_status(input port_cond_t c);
        logic [6:0] hi;
        hi = 7'h00;
        for (int k = 0; k < NUM_CAUSES; k++) if (c.cause[k]) hi = hi + 7'(k + 1);
        if (hi > 7'h0B) hi = 7'h0B;
        return {hi[3:0], 4'({1'b0, c.state}) + (c.pd_invalid ? 4'h8 : 4'h0)};
    endfunction
    function automatic safe_map_t mk(input logic [1:0] p, input safe_type_t t,
                                     input logic [7:0] o);
        return '{valid: 1'b1, port: p, dtype: t, byte_offset: o};
    endfunction
    task set_cond(input logic [1:0] p, input port_cond_t c);
        i_load = 1'b1;
        ld_port = p;
        ld_cond = c;
        exp_c[p] = c;
        tick;
        i_load = 1'b0;
        tick;
        for (int n = 0; n < NUM_PORTS; n++) begin
            check8("status", exp_status(exp_c[n]), o_cyclic_status[8*n +: 8]);
        end
    endtask
    task dict_rd(input logic [15:0] idx, input logic [7:0] sub, input logic ok,
                 input logic [7:0] d);
        i_dict_rd = 1'b1;
        i_dict_index = idx;
        i_dict_subindex = sub;
        tick;
        check8("dict ack", 8'h01, {7'h00, o_dict_ack});
        check8("dict ok", {7'h00, ok}, {7'h00, o_dict_ok});
        check8("dict data", d, o_dict_data);
    endtask
    task acc(input access_err_t e, input logic [7:0] add);
        i_acc_fail = 1'b1;
        i_acc_err = e;
        tick;
        check8("acc valid", 8'h01, {7'h00, o_acc_valid});
        check32("return code", {8'h80, add, 16'h0700}, o_host_access_return_code);
    endtask
    task map_wr(input logic [15:0] idx, input logic [7:0] sub, input logic rej,
                input safe_map_t e);
        i_map_wr = 1'b1;
        i_map_index = idx;
        i_map_subindex = sub;
        tick;
        check8("map reject", {7'h00, rej}, {7'h00, o_map_reject});
        check32("safe map", {18'h0, e}, {18'h0, o_safe_map});
    endtask
    task check_reset;
        check32("reset code", 32'h00000000, o_host_access_return_code);
        check32("reset map", {18'h0, mk(2'h0, DT_UINT, 8'h00)}, {18'h0, o_safe_map});
        i_rst_n = 1'b1;
        tick;
        check32("status after reset", 32'h00000000, o_cyclic_status);
    endtask
    ////////////////////////////////////////////////////////////////
    task test_status;
        port_cond_t c;
        for (int i = 0; i < NUM_CAUSES; i++) begin
            c = '{cause: 11'h001 << i, pd_invalid: i[0], state: port_state_t'(i % 5)};
            set_cond(2'(i % 4), c);
        end
        set_cond(2'h0, '{cause: 11'h005, pd_invalid: 1'b0, state: ST_COMM_HALTED});
        set_cond(2'h1, '{cause: 11'h7FF, pd_invalid: 1'b1, state: ST_DIG_OUT});
        set_cond(2'h2, '{cause: 11'h000, pd_invalid: 1'b1, state: ST_OPERATE});
        check8("operate invalid", 8'h0B, o_cyclic_status[23:16]);
    endtask
    task test_dict;
        // back to back reads, every port, then refused subindices and a foreign index
        for (int n = 1; n <= NUM_PORTS; n++) begin
            dict_rd(16'hF100, 8'(n), 1'b1, exp_status(exp_c[n-1]));
        end
        dict_rd(16'hF100, 8'h00, 1'b0, 8'h00);
        dict_rd(16'hF100, 8'h05, 1'b0, 8'h00);
        dict_rd(16'hF101, 8'h01, 1'b0, 8'h00);
        i_dict_rd = 1'b0;
        tick;
        check8("dict ack low", 8'h00, {7'h00, o_dict_ack});
    endtask
    task test_access;
        logic [7:0] adds [6];
        adds = '{8'h00, 8'h11, 8'h12, 8'h20, 8'h21, 8'h22};
        for (int i = 0; i < 6; i++) begin
            acc(access_err_t'(i), adds[i]);
        end
        i_acc_fail = 1'b0;
        tick;
        check8("acc valid low", 8'h00, {7'h00, o_acc_valid});
        check32("code held", 32'h80220700, o_host_access_return_code);
    endtask
    // checksum choice and safety address stay with the configurator; no pin carries them
    task test_map;
        map_wr(16'h6011, 8'h01, 1'b0, mk(2'h1, DT_UDINT, 8'h00));
        map_wr(16'h6004, 8'h01, 1'b0, mk(2'h0, DT_INT, 8'h00));
        map_wr(16'h6020, 8'h02, 1'b0, mk(2'h2, DT_BIT, 8'h01));
        map_wr(16'h6033, 8'h03, 1'b0, mk(2'h3, DT_UINT, 8'h02));
        map_wr(16'h6032, 8'hFF, 1'b0, mk(2'h3, DT_DINT, 8'hFE));
        map_wr(16'h7012, 8'h01, 1'b1, mk(2'h3, DT_DINT, 8'hFE));
        map_wr(16'h6043, 8'h01, 1'b1, mk(2'h3, DT_DINT, 8'hFE));
        map_wr(16'h6005, 8'h01, 1'b1, mk(2'h3, DT_DINT, 8'hFE));
        map_wr(16'h6013, 8'h00, 1'b1, mk(2'h3, DT_DINT, 8'hFE));
        i_map_wr = 1'b0;
        tick;
    endtask
    // mid-run reset must bring back the default mapping over a written one
    task test_reset;
        i_rst_n = 1'b0;
        exp_c = '{default: '0};
        tick;
        tick;
        check_reset;
        set_cond(2'h3, '{cause: 11'h000, pd_invalid: 1'b0, state: ST_DIG_IN});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {i_rst_n, i_load, ld_port, i_dict_rd, i_acc_fail, i_map_wr} = '0;
        {i_dict_index, i_dict_subindex, i_map_index, i_map_subindex} = '0;
        ld_cond = '0;
        exp_c = '{default: '0};
        i_acc_err = ACC_REFUSED;
        repeat (12) @(posedge i_clk);
        #2;
        check_reset;
        test_status;
        test_dict;
        test_access;
        test_map;
        test_reset;
        end_sim;
    end
    // the whole run is some 70 cycles; this allows many times that
    initial begin
        #200000;
        num_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
